// ===== logic/adcm_defines.vh
// Constants for the dual-channel muxed converter output block.
// Assumes inclusion by bare name from files under logic/ and tb/.
`ifndef ADCM_DEFINES_VH
`define ADCM_DEFINES_VH

// Sample widths
`define ADCM_SAMPLE_W        10
`define ADCM_PAIR_W          20
`define ADCM_MSB             9

// Pipeline shape: nine half-cycle stages, five cycles to the first channel
`define ADCM_STAGES          9
`define ADCM_LATENCY_CYCLES  5

// Buffer shape
`define ADCM_FIFO_DEPTH      16
`define ADCM_FIFO_AW         4

// Register byte offsets
`define ADCM_OFS_CTRL        8'h00
`define ADCM_OFS_STATUS      8'h04
`define ADCM_OFS_DATA        8'h08
`define ADCM_OFS_LAST        8'h0c

// Control register fields and reset value
`define ADCM_CTRL_TWOS       0
`define ADCM_CTRL_OUT_DIS    1
`define ADCM_CTRL_SHUTDOWN   2
`define ADCM_CTRL_RESET      3'h0

// Status register fields
`define ADCM_ST_NONEMPTY     0
`define ADCM_ST_FULL         1
`define ADCM_ST_OVERFLOW     2
`define ADCM_ST_LEVEL_LO     4

// Data register fields
`define ADCM_DATA_B_LO       16
`define ADCM_DATA_VALID      31

// AHB transfer type
`define ADCM_HTRANS_NONSEQ   2'h2

`endif

// ===== logic/adcm_half_stage.v
// One half-cycle pipeline stage, rising or falling edge by parameter.
// Assumes one free-running clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module adcm_half_stage #(
    parameter WIDTH   = 20,
    parameter FALLING = 0
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire [WIDTH-1:0] d,
    output reg  [WIDTH-1:0] q
);

    generate
        if (FALLING != 0) begin : g_fall
            always @(negedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    q <= {WIDTH{1'b0}};
                end else begin
                    q <= d;
                end
            end
        end else begin : g_rise
            always @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    q <= {WIDTH{1'b0}};
                end else begin
                    q <= d;
                end
            end
        end
    endgenerate

endmodule // adcm_half_stage

`default_nettype wire

// ===== logic/adcm_fifo.v
// Synchronous FIFO with valid/ready on both sides, flop storage.
// Assumes one clock and an asynchronous active-low reset.
`timescale 1ns/1ns
`default_nettype none

module adcm_fifo #(
    parameter WIDTH = 20,
    parameter DEPTH = 16,
    parameter AW    = 4
) (
    input  wire             hclk,
    input  wire             hresetn,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data,
    output wire [AW:0]      level
);

    reg [WIDTH-1:0] mem_reg [0:DEPTH-1];
    reg [AW-1:0]    wr_ptr_reg;
    reg [AW-1:0]    rd_ptr_reg;
    reg [AW:0]      count_reg;
    wire            push;
    wire            pop;

    assign in_ready  = (count_reg != DEPTH[AW:0]);
    assign out_valid = (count_reg != {(AW+1){1'b0}});
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem_reg[rd_ptr_reg];
    assign level     = count_reg;

    always @(posedge hclk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ptr_reg <= {AW{1'b0}};
            rd_ptr_reg <= {AW{1'b0}};
            count_reg  <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_reg <= wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= rd_ptr_reg + 1'b1;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 1'b1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 1'b1;
            end
        end
    end

endmodule // adcm_fifo

`default_nettype wire

// ===== logic/adcm_top.v
// Output side of a dual-channel pipelined converter: simultaneous capture,
// nine half-cycle stages, one shared three-state bus muxed by clock phase,
// a channel indicator, code format, output enable and shutdown hold.
// Assumes hclk is the converter clock, samples arrive synchronous to it,
// and an AHB-Lite master with a single slave on the bus.
//
// The register offsets and the AHB-Lite register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "adcm_defines.vh"

module adcm_top (
    input  wire        hclk,
    input  wire        hresetn,
    // Converted codes, offset binary
    input  wire [9:0]  first_input,
    input  wire [9:0]  second_input,
    // AHB-Lite slave
    input  wire        hsel,
    input  wire [31:0] haddr,
    input  wire [1:0]  htrans,
    input  wire        hwrite,
    input  wire [2:0]  hsize,
    input  wire [31:0] hwdata,
    input  wire        hready,
    output wire        hreadyout,
    output wire        hresp,
    output wire [31:0] hrdata,
    // Three-state outputs
    output wire [9:0]  muxed_sample_bus,
    output wire        muxed_sample_bus_oe_n,
    output wire        chan_ind,
    output wire        chan_ind_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations

    localparam PW = `ADCM_PAIR_W;
    localparam SW = `ADCM_SAMPLE_W;
    localparam NS = `ADCM_STAGES;

    reg  [2:0]      ctrl_reg;
    reg             overflow_reg;
    reg  [PW-1:0]   cap_reg;
    wire [PW-1:0]   stage_q [0:NS];
    reg  [SW-1:0]   out_a_reg;
    reg  [SW-1:0]   out_b_reg;
    reg             ph_rise_reg;
    reg             ph_fall_reg;
    wire            twos_sel;
    wire            out_disable;
    wire            shutdown_in;
    wire [SW-1:0]   conv_a;
    wire [SW-1:0]   conv_b;
    wire            fifo_in_ready;
    wire            fifo_out_valid;
    wire            fifo_pop;
    wire [PW-1:0]   fifo_out_data;
    wire [`ADCM_FIFO_AW:0] fifo_level;
    wire            push_req;
    reg             wr_pend_reg;
    reg  [7:0]      wr_addr_reg;
    reg  [31:0]     rdata_reg;
    reg  [31:0]     rdata_next;
    wire            addr_phase;
    wire            rd_take;
    wire [7:0]      ofs;
    // Register strobes
    wire            ctrl_wr;
    wire            status_wr;
    wire            push_drop;

    assign twos_sel    = ctrl_reg[`ADCM_CTRL_TWOS];
    assign out_disable = ctrl_reg[`ADCM_CTRL_OUT_DIS];
    assign shutdown_in = ctrl_reg[`ADCM_CTRL_SHUTDOWN];

    ////////////////////////////////////////////////////////////////////////
    // Capture and half-cycle pipeline

    // Both channels land in one register on the same edge
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cap_reg <= {PW{1'b0}};
        end else begin
            cap_reg <= {second_input, first_input};
        end
    end

    assign stage_q[0] = cap_reg;

    // Odd stages on the falling edge so that the ninth ends at 4.5 cycles
    genvar k;
    generate
        for (k = 0; k < NS; k = k + 1) begin : g_stage
            adcm_half_stage #(
                .WIDTH   (PW),
                .FALLING (((k % 2) == 0) ? 1 : 0)
            ) u_stage (
                .hclk    (hclk),
                .hresetn (hresetn),
                .d       (stage_q[k]),
                .q       (stage_q[k+1])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // Code format

    // Offset binary to two's complement is a flip of the top bit only
    assign conv_a = {stage_q[NS][`ADCM_MSB] ^ twos_sel,
                     stage_q[NS][`ADCM_MSB-1:0]};
    assign conv_b = {stage_q[NS][SW+`ADCM_MSB] ^ twos_sel,
                     stage_q[NS][SW+`ADCM_MSB-1:SW]};

    ////////////////////////////////////////////////////////////////////////
    // Output latches, rising for the first channel, falling for the second

    // Shutdown freezes the latch
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_a_reg   <= {SW{1'b0}};
        end else if (!shutdown_in) begin
            out_a_reg   <= conv_a;
        end else begin
            out_a_reg   <= out_a_reg;
        end
    end

    // Stage nine still holds the same sample until this edge
    always @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            out_b_reg   <= {SW{1'b0}};
        end else if (!shutdown_in) begin
            out_b_reg   <= conv_b;
        end else begin
            out_b_reg   <= out_b_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Channel indicator

    // Phase toggles on each rising edge that latches a first-channel word
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_rise_reg <= 1'b0;
        end else if (!shutdown_in) begin
            ph_rise_reg <= ~ph_rise_reg;
        end else begin
            ph_rise_reg <= ph_rise_reg;
        end
    end

    // Copy at the falling edge brings the indicator back to zero
    always @(negedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ph_fall_reg <= 1'b0;
        end else if (!shutdown_in) begin
            ph_fall_reg <= ph_rise_reg;
        end else begin
            ph_fall_reg <= ph_fall_reg;
        end
    end

    // Indicator built from two flops: no clock gating on the data path,
    // and it lags the clock only by the flop delay
    assign chan_ind = ph_rise_reg ^ ph_fall_reg;

    assign muxed_sample_bus = chan_ind ? out_a_reg : out_b_reg;

    // One enable floats the bus and the indicator together
    assign muxed_sample_bus_oe_n = out_disable;
    assign chan_ind_oe_n         = out_disable;

    ////////////////////////////////////////////////////////////////////////
    // Sample buffer toward software

    // A pair enters whenever a first-channel word is latched; a full
    // buffer drops it and marks the loss rather than stalling the converter
    assign push_req = !shutdown_in;
    assign push_drop = push_req && !fifo_in_ready;

    adcm_fifo #(
        .WIDTH (PW),
        .DEPTH (`ADCM_FIFO_DEPTH),
        .AW    (`ADCM_FIFO_AW)
    ) u_fifo (
        .hclk      (hclk),
        .hresetn   (hresetn),
        .in_valid  (push_req),
        .in_ready  (fifo_in_ready),
        .in_data   ({conv_b, conv_a}),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop),
        .out_data  (fifo_out_data),
        .level     (fifo_level)
    );

    ////////////////////////////////////////////////////////////////////////
    // AHB-Lite slave, zero wait states

    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = rdata_reg;
    assign addr_phase = hsel && hready && (htrans == `ADCM_HTRANS_NONSEQ);
    assign ofs        = haddr[7:0];
    assign rd_take    = addr_phase && !hwrite;
    assign fifo_pop   = rd_take && (ofs == `ADCM_OFS_DATA) && fifo_out_valid;

    // Writes land in the data phase, one edge after the address was taken
    assign ctrl_wr    = wr_pend_reg && (wr_addr_reg == `ADCM_OFS_CTRL);
    assign status_wr  = wr_pend_reg && (wr_addr_reg == `ADCM_OFS_STATUS);

    // Read data is formed in the address phase so it leaves a flop
    always @* begin
        rdata_next = 32'h0000_0000;
        case (ofs)
            `ADCM_OFS_CTRL: begin
                rdata_next[2:0] = ctrl_reg;
            end
            `ADCM_OFS_STATUS: begin
                rdata_next[`ADCM_ST_NONEMPTY] = fifo_out_valid;
                rdata_next[`ADCM_ST_FULL]     = !fifo_in_ready;
                rdata_next[`ADCM_ST_OVERFLOW] = overflow_reg;
                rdata_next[`ADCM_ST_LEVEL_LO+`ADCM_FIFO_AW:`ADCM_ST_LEVEL_LO] = fifo_level;
            end
            `ADCM_OFS_DATA: begin
                if (fifo_out_valid) begin
                    rdata_next[SW-1:0] = fifo_out_data[SW-1:0];
                    rdata_next[`ADCM_DATA_B_LO+SW-1:`ADCM_DATA_B_LO] =
                        fifo_out_data[PW-1:SW];
                    rdata_next[`ADCM_DATA_VALID] = 1'b1;
                end
            end
            `ADCM_OFS_LAST: begin
                rdata_next[SW-1:0] = out_a_reg;
                rdata_next[`ADCM_DATA_B_LO+SW-1:`ADCM_DATA_B_LO] = out_b_reg;
            end
            default: begin
                rdata_next = 32'h0000_0000;
            end
        endcase
    end

    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rdata_reg   <= 32'h0000_0000;
            wr_pend_reg <= 1'b0;
            wr_addr_reg <= 8'h00;
        end else begin
            wr_pend_reg <= addr_phase && hwrite;
            if (addr_phase) begin
                wr_addr_reg <= ofs;
            end
            if (rd_take) begin
                rdata_reg <= rdata_next;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control and sticky status

    // Only the three low bits exist; the rest of the word is ignored
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_reg <= `ADCM_CTRL_RESET;
        end else if (ctrl_wr) begin
            ctrl_reg <= hwdata[2:0];
        end
    end

    // A loss in the same cycle as the clear keeps the flag set
    always @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            overflow_reg <= 1'b0;
        end else if (push_drop) begin
            overflow_reg <= 1'b1;
        end else if (status_wr && hwdata[`ADCM_ST_OVERFLOW]) begin
            overflow_reg <= 1'b0;
        end
    end

endmodule // adcm_top

`default_nettype wire

// ===== tb/adcm_properties.sv
// Checker for the muxed converter output block.
// Assumes it is bound to adcm_top and sees only that module's ports.
`timescale 1ns/1ns
`default_nettype none
`include "adcm_defines.vh"
module adcm_properties (
    input wire logic        hclk,
    input wire logic        hresetn,
    input wire logic [9:0]  first_input,
    input wire logic [9:0]  second_input,
    input wire logic        hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0]  htrans,
    input wire logic        hwrite,
    input wire logic [2:0]  hsize,
    input wire logic [31:0] hwdata,
    input wire logic        hready,
    input wire logic        hreadyout,
    input wire logic        hresp,
    input wire logic [31:0] hrdata,
    input wire logic [9:0]  muxed_sample_bus,
    input wire logic        muxed_sample_bus_oe_n,
    input wire logic        chan_ind,
    input wire logic        chan_ind_oe_n
);
////////////////////////////////////////////////////////////////////////////////
    logic       wr_ph_reg;
    logic [2:0] ctrl_reg;
    logic [2:0] age_reg;
    logic [3:0] run_reg;
    logic       ok;
    // Shadow control word; data checks skip the cycles just after a change
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_ph_reg <= 1'b0;
            ctrl_reg  <= 3'h0;
            age_reg   <= 3'h7;
            run_reg   <= 4'h0;
        end else begin
            if (hready)
                wr_ph_reg <= hsel && hwrite && htrans == `ADCM_HTRANS_NONSEQ
                             && haddr[7:0] == `ADCM_OFS_CTRL;
            if (wr_ph_reg && hready) begin
                ctrl_reg <= hwdata[2:0];
                age_reg  <= 3'h0;
            end else if (age_reg != 3'h7) begin
                age_reg <= age_reg + 3'h1;
            end
            // Pipeline still holds reset zeros just after release
            if (run_reg != 4'h8)
                run_reg <= run_reg + 4'h1;
        end
    end
    assign ok = run_reg == 4'h8 && age_reg >= 3'h3 && !ctrl_reg[2];
////////////////////////////////////////////////////////////////////////////////
    a_first_offset: assert property (
        @(negedge hclk) disable iff (!hresetn)
        ok && !ctrl_reg[0] |-> muxed_sample_bus == $past(first_input, 6))
        else $error("first channel word wrong in offset binary");
    a_first_twos: assert property (
        @(negedge hclk) disable iff (!hresetn)
        ok && ctrl_reg[0] |-> muxed_sample_bus == ($past(first_input, 6) ^ 10'h200))
        else $error("first channel word wrong in twos complement");
    a_second_offset: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ok && !ctrl_reg[0] |-> muxed_sample_bus == $past(second_input, 6))
        else $error("second channel word wrong in offset binary");
    a_second_twos: assert property (
        @(posedge hclk) disable iff (!hresetn)
        ok && ctrl_reg[0] |-> muxed_sample_bus == ($past(second_input, 6) ^ 10'h200))
        else $error("second channel word wrong in twos complement");
    a_ind_high: assert property (
        @(negedge hclk) disable iff (!hresetn) ok |-> chan_ind)
        else $error("indicator low in first channel phase");
    a_ind_low: assert property (
        @(posedge hclk) disable iff (!hresetn) ok |-> !chan_ind)
        else $error("indicator high in second channel phase");
    a_oe_follows: assert property (
        @(posedge hclk) disable iff (!hresetn) age_reg != 3'h0
        |-> muxed_sample_bus_oe_n == ctrl_reg[1] && chan_ind_oe_n == ctrl_reg[1])
        else $error("output enable does not follow control");
    a_shut_hold: assert property (
        @(posedge hclk) disable iff (!hresetn) ctrl_reg[2] && age_reg >= 3'h2
        |-> $stable(muxed_sample_bus) && $stable(chan_ind))
        else $error("outputs moved during shutdown");
endmodule // adcm_properties
`default_nettype wire

// ===== tb/adcm_receiver.sv
// Receiver model capturing the muxed sample words into pairs.
// Assumes the converter clock and the three-state bus of adcm_top.
`timescale 1ns/1ns
`default_nettype none
module adcm_receiver (
    input  wire logic       hclk,
    input  wire logic [9:0] bus_in,
    input  wire logic       bus_oe_n,
    input  wire logic       ind_in,
    input  wire logic       ind_oe_n,
    output var  logic [9:0] pair_a,
    output var  logic [9:0] pair_b
);
    logic [9:0] line;
    logic       ind_line;
    logic [9:0] a_hold;
    // No pull on the lines: a floated line shows the inverse of the value still driven onto it
    assign line     = bus_oe_n ? ~bus_in : bus_in;
    assign ind_line = ind_oe_n ? ~ind_in : ind_in;
    always @(negedge hclk) begin
        if (ind_line)
            a_hold <= line;
    end
    always @(posedge hclk) begin
        if (!ind_line) begin
            pair_a <= a_hold;
            pair_b <= line;
        end
    end
endmodule // adcm_receiver
`default_nettype wire

// ===== tb/tb.sv
// Self-checking bench for adcm_top with an AHB-Lite master and a receiver.
// Assumes the design under logic/ and the receiver and checker under tb/.
`timescale 1ns/1ns
`default_nettype none
`include "adcm_defines.vh"
module tb;
    logic        hclk;
    logic        hresetn;
    logic [9:0]  first_input;
    logic [9:0]  second_input;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire  [9:0]  muxed_sample_bus;
    wire         muxed_sample_bus_oe_n;
    wire         chan_ind;
    wire         chan_ind_oe_n;
    logic [9:0]  rx_a;
    logic [9:0]  rx_b;
    logic [31:0] rd;
    int          failures;
    int          n_compared;
    int          i;
    // Rows: first, second, format, expected first word, expected second word
    logic [49:0] rows [4] = '{{10'h3ff, 10'h000, 10'h0, 10'h3ff, 10'h000},
                              {10'h200, 10'h1ff, 10'h1, 10'h000, 10'h3ff},
                              {10'h001, 10'h2aa, 10'h1, 10'h201, 10'h0aa},
                              {10'h155, 10'h3fe, 10'h0, 10'h155, 10'h3fe}};
    adcm_top u_adcm_top (.hclk, .hresetn, .first_input, .second_input, .hsel, .haddr,
        .htrans, .hwrite, .hsize(3'h2), .hwdata, .hready(hreadyout), .hreadyout, .hresp,
        .hrdata, .muxed_sample_bus, .muxed_sample_bus_oe_n, .chan_ind, .chan_ind_oe_n);
    adcm_receiver u_adcm_receiver (.hclk, .bus_in(muxed_sample_bus),
        .bus_oe_n(muxed_sample_bus_oe_n), .ind_in(chan_ind), .ind_oe_n(chan_ind_oe_n),
        .pair_a(rx_a), .pair_b(rx_b));
////////////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        $display("compared %0d failures %0d", n_compared, failures);
        if (failures == 0 && n_compared > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic cmp_r(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            failures++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_w(input logic [9:0] got, input logic [9:0] exp);
        cmp_r({22'h0, got}, {22'h0, exp});
    endtask
    task automatic wait_ready;
        int n;
        n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 50) begin
                failures++;
                close_out();
            end
            @(posedge hclk);
        end
    endtask
    task automatic ahb(input logic wr, input logic [31:0] addr, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= addr;
        htrans <= `ADCM_HTRANS_NONSEQ;
        hwrite <= wr;
        wait_ready();
        hsel   <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
////////////////////////////////////////////////////////////////////////////////
    initial begin
        hclk = 1'b0;
        forever #2 hclk = ~hclk;
    end
    initial begin
        hresetn = 1'b0;
        first_input = 10'h000;
        second_input = 10'h000;
        hsel = 1'b0;
        haddr = 32'h0;
        htrans = 2'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        failures = 0;
        n_compared = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        ahb(1'b0, `ADCM_OFS_CTRL, 32'h0);
        cmp_r(rd, 32'h0);
        cmp_r({31'h0, hresp}, 32'h0);
        ahb(1'b0, 32'h10, 32'h0);
        cmp_r(rd, 32'h0);
        ahb(1'b1, `ADCM_OFS_CTRL, 32'h2);
        repeat (2) @(posedge hclk);
        cmp_r({30'h0, muxed_sample_bus_oe_n, chan_ind_oe_n}, 32'h3);
        for (i = 0; i < 4; i++) begin
            ahb(1'b1, `ADCM_OFS_CTRL, {31'h0, rows[i][20]});
            first_input  <= rows[i][49:40];
            second_input <= rows[i][39:30];
            repeat (10) @(posedge hclk);
            cmp_w(rx_a, rows[i][19:10]);
            cmp_w(rx_b, rows[i][9:0]);
            ahb(1'b0, `ADCM_OFS_LAST, 32'h0);
            cmp_r(rd, {6'h0, rows[i][9:0], 6'h0, rows[i][19:10]});
        end
        // Drain under shutdown, then refill with one known pair until full
        ahb(1'b1, `ADCM_OFS_CTRL, 32'h4);
        first_input  <= 10'h2c3;
        second_input <= 10'h13c;
        i = 0;
        do begin
            ahb(1'b0, `ADCM_OFS_DATA, 32'h0);
            i++;
        end while (rd[31] === 1'b1 && i < 40);
        cmp_r(rd[31], 32'h0);
        ahb(1'b1, `ADCM_OFS_CTRL, 32'h0);
        repeat (30) @(posedge hclk);
        ahb(1'b1, `ADCM_OFS_CTRL, 32'h4);
        first_input <= 10'h0f0;
        ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
        cmp_r(rd, 32'h107);
        for (i = 0; i < 16; i++) begin
            ahb(1'b0, `ADCM_OFS_DATA, 32'h0);
            cmp_r(rd, 32'h813c02c3);
        end
        ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
        cmp_r(rd, 32'h4);
        ahb(1'b1, `ADCM_OFS_STATUS, 32'h4);
        ahb(1'b0, `ADCM_OFS_STATUS, 32'h0);
        cmp_r(rd, 32'h0);
        cmp_w(rx_a, 10'h2c3);
        ahb(1'b1, `ADCM_OFS_CTRL, 32'h0);
        repeat (10) @(posedge hclk);
        cmp_w(rx_a, 10'h0f0);
        // Mid-run reset with shutdown and disable set brings all back to idle
        ahb(1'b1, `ADCM_OFS_CTRL, 32'h6);
        hresetn <= 1'b0;
        repeat (3) @(posedge hclk);
        cmp_r(hrdata, 32'h0);
        cmp_w(muxed_sample_bus, 10'h000);
        cmp_r({30'h0, chan_ind, muxed_sample_bus_oe_n}, 32'h0);
        hresetn <= 1'b1;
        ahb(1'b0, `ADCM_OFS_CTRL, 32'h0);
        cmp_r(rd, 32'h0);
        repeat (10) @(posedge hclk);
        cmp_w(rx_a, 10'h0f0);
        cmp_w(rx_b, 10'h13c);
        close_out();
    end
endmodule // tb
bind adcm_top adcm_properties u_adcm_properties (.hclk, .hresetn, .first_input,
    .second_input, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready, .hreadyout,
    .hresp, .hrdata, .muxed_sample_bus, .muxed_sample_bus_oe_n, .chan_ind, .chan_ind_oe_n);
`default_nettype wire
